//--- pkg/sram_ctl_map.svh
// timing constants and pin-level encodings for the sram host controller
`ifndef SRAM_CTL_MAP_SVH
`define SRAM_CTL_MAP_SVH

`define CLK_PERIOD_NS            10
`define POWERUP_WAIT_TIME_US     100
`define ADDR_TO_DATA_TIME_NS     10
`define READ_CYCLE_TIME_NS       10
`define WRITE_CYCLE_TIME_NS      10
`define ADDR_SETUP_END_TIME_NS   7
`define WRITE_PULSE_TIME_NS      7
`define BYTE_SEL_END_TIME_NS     7
`define WRITE_DATA_SETUP_TIME_NS 5
`define STROBE_TO_TRISTATE_TIME_NS 5
`define OUT_DRIVE_DATA_TIME_NS   6

// cycle counts, least times rounded up
`define CYC_UP(ns)        (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POWERUP_CYCLES    ((`POWERUP_WAIT_TIME_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// the first sync flop would otherwise sample right at the access time
`define SAMPLE_MARGIN_CYCLES 1
`define READ_CYCLES       (`CYC_UP(`ADDR_TO_DATA_TIME_NS) + `SAMPLE_MARGIN_CYCLES)
`define WRITE_PULSE_CYCLES `CYC_UP(`WRITE_PULSE_TIME_NS + `WRITE_DATA_SETUP_TIME_NS)
`define WRITE_WE_OE_CYCLES `CYC_UP(`STROBE_TO_TRISTATE_TIME_NS + `WRITE_DATA_SETUP_TIME_NS)

`define TIMER_W           17
`define ADDR_W            18
`define DATA_W            16
`define BYTE_W            8
`define PIN_INACTIVE      1'B1
`define PIN_ACTIVE        1'B0
`define BYTE_SEL_NONE     2'H3

`endif

//--- pkg/sram_ctl_pkg.sv
// types shared by the sram host controller files
`include "sram_ctl_map.svh"
package sram_ctl_pkg;

    typedef struct packed {
        logic                 valid;
        logic                 write;
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   wdata;
        logic [1:0]           byte_en;
    } req_t;

    typedef struct packed {
        logic                 chip_sel_n;
        logic                 out_drive_n;
        logic                 write_strobe_n;
        logic                 low_byte_sel_n;
        logic                 high_byte_sel_n;
        logic [`ADDR_W-1:0]   addr;
        logic [`DATA_W-1:0]   data_bus_out;
        logic [`DATA_W-1:0]   data_bus_oe;
    } pins_t;

    typedef enum logic [2:0] {
        ST_POWERUP,
        ST_IDLE,
        ST_READ,
        ST_WRITE,
        ST_WRITE_END
    } phase_t;

endpackage : sram_ctl_pkg

//--- src/cycle_timer.sv
// down counter used for power-up wait and access phase lengths
`include "sram_ctl_map.svh"
module cycle_timer
    import sram_ctl_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire logic                  load,
    input  wire logic [`TIMER_W-1:0]   count,
    output logic                       done
);
    typedef struct packed {
        logic [`TIMER_W-1:0] cnt;
        logic                done;
    } timer_state_t;

    timer_state_t state_q;
    timer_state_t state_d;

    always_comb
    begin
        state_d = state_q;
        if (load)
        begin
            state_d.cnt  = count;
            state_d.done = (count == `TIMER_W'H0);
        end
        else if (state_q.cnt != `TIMER_W'H0)
        begin
            state_d.cnt  = state_q.cnt - `TIMER_W'H1;
            state_d.done = (state_q.cnt == `TIMER_W'H1);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    assign done = state_q.done;
endmodule : cycle_timer

//--- src/sram_host_ctl.sv
// host controller that sequences async sram strobes for single accesses
// Summary of operation
// - write starts only with chip select, strobe and a select low
// - write ends on one rising edge; data held through it
// - write strobe stays high throughout every read
// - address is valid before or with chip select falling
// - wait 100 us after reset before the first access
// - address stable 7 ns before write end; cycle at least 10 ns
// - write data driven 5 ns before write end, released after
// - byte select and write strobe low at least 7 ns
// - strobe write cycle covers tristate delay plus data setup
`include "sram_ctl_map.svh"
module sram_host_ctl
    import sram_ctl_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 resetn,
    input  sram_ctl_pkg::req_t        req,
    output logic                      req_ready,
    output logic                      rsp_valid,
    output logic [`DATA_W-1:0]        rsp_rdata,
    output sram_ctl_pkg::pins_t       pins,
    input  wire logic [`DATA_W-1:0]   data_bus_in
);
    import sram_ctl_pkg::*;

    typedef struct packed {
        phase_t               phase;
        logic                 ready;
        logic                 rsp_valid;
        logic [`DATA_W-1:0]   rdata;
        pins_t                pins;
        logic [`DATA_W-1:0]   in_meta;
        logic [`DATA_W-1:0]   in_sync;
        logic                 timer_load;
        logic [`TIMER_W-1:0]  timer_count;
        logic                 first;
    } ctl_state_t;

    ctl_state_t state_q;
    ctl_state_t state_d;
    logic       timer_done;

    function automatic pins_t idle_pins(input pins_t p);
        pins_t r;
        r                 = p;
        r.chip_sel_n      = `PIN_INACTIVE;
        r.out_drive_n     = `PIN_INACTIVE;
        r.write_strobe_n  = `PIN_INACTIVE;
        r.low_byte_sel_n  = `PIN_INACTIVE;
        r.high_byte_sel_n = `PIN_INACTIVE;
        r.data_bus_oe     = '0;
        return r;
    endfunction : idle_pins

    cycle_timer u_timer (
        .clk    (clk),
        .resetn (resetn),
        .load   (state_q.timer_load),
        .count  (state_q.timer_count),
        .done   (timer_done)
    );

    always_comb
    begin
        state_d            = state_q;
        state_d.timer_load = 1'B0;
        state_d.rsp_valid  = 1'B0;
        state_d.in_meta    = data_bus_in;
        state_d.in_sync    = state_q.in_meta;
        case (state_q.phase)
            ST_POWERUP:
            begin
                if (state_q.first)
                begin
                    state_d.first       = 1'B0;
                    state_d.timer_load  = 1'B1;
                    state_d.timer_count = `TIMER_W'(`POWERUP_CYCLES);
                end
                else if (timer_done)
                begin
                    state_d.phase = ST_IDLE;
                    state_d.ready = 1'B1;
                end
            end
            ST_IDLE:
            begin
                state_d.pins = idle_pins(state_q.pins);
                if (req.valid && state_q.ready && req.byte_en != 2'H0)
                begin
                    state_d.ready                = 1'B0;
                    state_d.pins.addr            = req.addr;
                    state_d.pins.chip_sel_n      = `PIN_ACTIVE;
                    state_d.pins.low_byte_sel_n  = ~req.byte_en[0];
                    state_d.pins.high_byte_sel_n = ~req.byte_en[1];
                    state_d.timer_load           = 1'B1;
                    if (req.write)
                    begin
                        // strobe falls with chip select; both are low with a select
                        state_d.phase                = ST_WRITE;
                        state_d.pins.write_strobe_n  = `PIN_ACTIVE;
                        state_d.pins.out_drive_n     = `PIN_INACTIVE;
                        state_d.pins.data_bus_out    = req.wdata;
                        state_d.pins.data_bus_oe     = {{`BYTE_W{req.byte_en[1]}},
                                                        {`BYTE_W{req.byte_en[0]}}};
                        state_d.timer_count = `TIMER_W'(`WRITE_PULSE_CYCLES);
                    end
                    else
                    begin
                        state_d.phase               = ST_READ;
                        state_d.pins.write_strobe_n = `PIN_INACTIVE;
                        state_d.pins.out_drive_n    = `PIN_ACTIVE;
                        // one spare cycle: the first sync flop must see settled data
                        state_d.timer_count = `TIMER_W'(`READ_CYCLES);
                    end
                end
            end
            ST_READ:
            begin
                if (!state_q.timer_load && timer_done)
                begin
                    state_d.phase     = ST_IDLE;
                    state_d.rsp_valid = 1'B1;
                    state_d.rdata     = state_q.in_sync;
                    state_d.pins      = idle_pins(state_q.pins);
                    state_d.ready     = 1'B1;
                end
            end
            ST_WRITE:
            begin
                if (!state_q.timer_load && timer_done)
                begin
                    // all strobes rise on one edge; data is kept one cycle more
                    state_d.phase                = ST_WRITE_END;
                    state_d.pins.chip_sel_n      = `PIN_INACTIVE;
                    state_d.pins.write_strobe_n  = `PIN_INACTIVE;
                    state_d.pins.low_byte_sel_n  = `PIN_INACTIVE;
                    state_d.pins.high_byte_sel_n = `PIN_INACTIVE;
                end
            end
            ST_WRITE_END:
            begin
                state_d.phase     = ST_IDLE;
                state_d.pins      = idle_pins(state_q.pins);
                state_d.rsp_valid = 1'B1;
                state_d.ready     = 1'B1;
            end
            default:
            begin
                state_d.phase = ST_IDLE;
                state_d.pins  = idle_pins(state_q.pins);
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            state_q                      <= '0;
            state_q.phase                <= ST_POWERUP;
            state_q.first                <= 1'B1;
            state_q.pins.chip_sel_n      <= `PIN_INACTIVE;
            state_q.pins.out_drive_n     <= `PIN_INACTIVE;
            state_q.pins.write_strobe_n  <= `PIN_INACTIVE;
            state_q.pins.low_byte_sel_n  <= `PIN_INACTIVE;
            state_q.pins.high_byte_sel_n <= `PIN_INACTIVE;
        end
        else
            state_q <= state_d;
    end

    assign req_ready = state_q.ready;
    assign rsp_valid = state_q.rsp_valid;
    assign rsp_rdata = state_q.rdata;
    assign pins      = state_q.pins;
endmodule : sram_host_ctl

//--- verif/sram_host_ctl_monitor.sv
// pin-level assertions for the sram host controller
`include "sram_ctl_map.svh"
module sram_host_ctl_monitor
    import sram_ctl_pkg::*;
(
    input wire logic                 clk,
    input wire logic                 resetn,
    input sram_ctl_pkg::req_t        req,
    input wire logic                 req_ready,
    input wire logic                 rsp_valid,
    input wire logic [`DATA_W-1:0]   rsp_rdata,
    input sram_ctl_pkg::pins_t       pins,
    input wire logic [`DATA_W-1:0]   data_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rd_we_high_a: assert property (
        !pins.chip_sel_n && !pins.out_drive_n |-> pins.write_strobe_n) else $error("we low in read");
    wr_start_a: assert property (
        $fell(pins.write_strobe_n) |-> !pins.chip_sel_n
        && !(pins.low_byte_sel_n && pins.high_byte_sel_n)) else $error("bad write start");
    wr_end_a: assert property (
        $rose(pins.write_strobe_n) |-> $rose(pins.chip_sel_n)
        && pins.low_byte_sel_n && pins.high_byte_sel_n) else $error("split write end");
    wr_hold_a: assert property (
        $rose(pins.write_strobe_n) |-> pins.data_bus_oe != 16'H0000
        && $stable(pins.data_bus_out)) else $error("data not held");
    wr_pulse_a: assert property (
        $fell(pins.write_strobe_n) |-> !pins.write_strobe_n [*2]) else $error("short pulse");
    addr_hold_a: assert property (
        !pins.chip_sel_n && !$fell(pins.chip_sel_n) |-> $stable(pins.addr)) else $error("addr moved");
    wr_oe_off_a: assert property (
        !pins.write_strobe_n |-> pins.out_drive_n) else $error("oe low in write");
    rd_len_a: assert property (
        $fell(pins.out_drive_n) |-> (!pins.out_drive_n && !pins.chip_sel_n) [*4])
        else $error("short read");
    sel_map_a: assert property (
        $fell(pins.chip_sel_n) |-> {pins.high_byte_sel_n, pins.low_byte_sel_n}
        == ~$past(req.byte_en)) else $error("select map");
    rd_c: cover property ($fell(pins.out_drive_n));
    wr_lo_c: cover property ($fell(pins.write_strobe_n) && pins.high_byte_sel_n);
    wr_hi_c: cover property ($fell(pins.write_strobe_n) && pins.low_byte_sel_n);
endmodule : sram_host_ctl_monitor

bind sram_host_ctl sram_host_ctl_monitor u_mon (.clk(clk), .resetn(resetn), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins),
    .data_bus_in(data_bus_in));

//--- verif/sram_model.sv
// behavioural async ram on the far side of the controller pins
`include "sram_ctl_map.svh"
module sram_model
    import sram_ctl_pkg::*;
(
    input wire logic               clk,
    input sram_ctl_pkg::pins_t     pins,
    output logic [`DATA_W-1:0]     data_bus_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
    logic [`DATA_W-1:0] last_q = 16'H0000;
    logic [1:0]         wr_act;
    logic [1:0]         rd_act;
    // chip select high blocks every strobe
    assign wr_act = {2{!pins.chip_sel_n && !pins.write_strobe_n}}
        & ~{pins.high_byte_sel_n, pins.low_byte_sel_n};
    assign rd_act = {2{!pins.chip_sel_n && !pins.out_drive_n && pins.write_strobe_n}}
        & ~{pins.high_byte_sel_n, pins.low_byte_sel_n};
    // lane stored when its overlap ends
    always @(negedge wr_act[0])
        if (!$isunknown(pins.addr)) mem[pins.addr][7:0] = pins.data_bus_out[7:0];
    always @(negedge wr_act[1])
        if (!$isunknown(pins.addr)) mem[pins.addr][15:8] = pins.data_bus_out[15:8];
    // no pull on the bus: a released lane shows a toggling pattern, not old data
    always @(posedge clk)
        last_q <= data_bus_in;
    always @*
        for (int i = 0; i < 16; i++)
            data_bus_in[i] = pins.data_bus_oe[i] ? pins.data_bus_out[i]
                : rd_act[i/8] ? mem[pins.addr][i] : ~last_q[i];
endmodule : sram_model

//--- verif/tb.sv
// self-checking bench for the sram host controller
`include "sram_ctl_map.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import sram_ctl_pkg::*;
    logic                clk;
    logic                resetn;
    req_t                req;
    logic                req_ready;
    logic                rsp_valid;
    logic [15:0]         rsp_rdata;
    pins_t               pins;
    logic [15:0]         data_bus_in;
    int                  err_total;
    int                  num_checks;
    logic [15:0]         q;

    sram_host_ctl u_dut (.clk(clk), .resetn(resetn), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .pins(pins), .data_bus_in(data_bus_in));
    sram_model u_ram (.clk(clk), .pins(pins), .data_bus_in(data_bus_in));

    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string m);
        num_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : check

    // called at a negedge; returns at the negedge that shows rsp_valid
    task automatic access(input logic w, input logic [17:0] a, input logic [15:0] d,
                          input logic [1:0] be);
        int n;
        req = '{valid: 1'B1, write: w, addr: a, wdata: d, byte_en: be};
        for (n = 0; req_ready !== 1'B1 && n < 20; n++) @(negedge clk);
        if (n >= 20)
        begin
            err_total++;
            $display("MISMATCH %0t never ready", $time);
            end_of_test();
        end
        @(negedge clk);
        req.valid = 1'B0;
        for (n = 0; rsp_valid !== 1'B1 && n < 20; n++) @(negedge clk);
        if (n >= 20)
        begin
            err_total++;
            $display("MISMATCH %0t no response", $time);
            end_of_test();
        end
        q = rsp_rdata;
    endtask : access

    task automatic t_powerup;
        int n;
        for (n = 0; req_ready !== 1'B1 && n < 10100; n++) @(negedge clk);
        check(16'(n >= `POWERUP_CYCLES), 16'H0001, "early ready");
        if (n >= 10100)
        begin
            err_total++;
            $display("MISMATCH %0t ready never rose", $time);
            end_of_test();
        end
    endtask : t_powerup

    task automatic t_full;
        access(1'B1, 18'H3FFFF, 16'HA55A, 2'H3);
        access(1'B0, 18'H3FFFF, 16'H0000, 2'H3);
        check(q, 16'HA55A, "full read");
        access(1'B1, 18'H00000, 16'H5AA5, 2'H3);
        access(1'B0, 18'H00000, 16'H0000, 2'H3);
        check(q, 16'H5AA5, "low addr read");
    endtask : t_full

    task automatic t_lanes;
        access(1'B1, 18'H00005, 16'H1234, 2'H3);
        access(1'B1, 18'H00005, 16'H77CD, 2'H1);
        access(1'B1, 18'H00005, 16'HEF88, 2'H2);
        access(1'B0, 18'H00005, 16'H0000, 2'H3);
        check(q, 16'HEFCD, "lane write");
        access(1'B0, 18'H00005, 16'H0000, 2'H1);
        check({8'H00, q[7:0]}, 16'H00CD, "low lane read");
        access(1'B0, 18'H00005, 16'H0000, 2'H2);
        check({q[15:8], 8'H00}, 16'HEF00, "high lane read");
    endtask : t_lanes

    // a request with no lane is never taken
    task automatic t_refuse;
        int hits;
        hits = 0;
        req = '{valid: 1'B1, write: 1'B1, addr: 18'H00005, wdata: 16'H0000, byte_en: 2'H0};
        repeat (10)
        begin
            @(negedge clk);
            hits += int'(rsp_valid !== 1'B0 || pins.chip_sel_n !== 1'B1);
        end
        check(16'(hits), 16'H0000, "empty request taken");
        access(1'B0, 18'H00005, 16'H0000, 2'H3);
        check(q, 16'HEFCD, "data after refusal");
    endtask : t_refuse

    initial
    begin
        clk = 1'B0;
        forever #5 clk = ~clk;
    end

    initial
    begin
        resetn = 1'B0;
        req = '0;
        err_total = 0;
        num_checks = 0;
        repeat (6) @(negedge clk);
        resetn = 1'B1;
        t_powerup();
        t_full();
        t_lanes();
        t_refuse();
        end_of_test();
    end
endmodule : tb
